/* File: include/tatc_cfg.svh */
// register map, field positions and reset values of the converter trigger block
`ifndef TATC_CFG_SVH
`define TATC_CFG_SVH
`define TATC_ADDR_CTRL      12'h000
`define TATC_ADDR_CYC_A     12'h004
`define TATC_ADDR_CYC_B     12'h008
`define TATC_ADDR_BUF_A     12'h00c
`define TATC_ADDR_BUF_B     12'h010
`define TATC_ADDR_CLR_EN    12'h014
`define TATC_ADDR_STATUS    12'h018
`define TATC_CTRL_WMASK     16'hc0ff
`define TATC_CLR_WMASK      16'h0007
`define TATC_CYC_RESET      16'hffff
`define TATC_CTRL_RESET     16'h0000
`define TATC_CLR_RESET      16'h0000
`define TATC_BIT_XFER_HI    15
`define TATC_BIT_XFER_LO    14
`define TATC_BIT_UP_A       7
`define TATC_BIT_DN_A       6
`define TATC_BIT_UP_B       5
`define TATC_BIT_DN_B       4
`define TATC_BIT_LK_A3      3
`define TATC_BIT_LK_A4      2
`define TATC_BIT_LK_B3      1
`define TATC_BIT_LK_B4      0
`define TATC_BIT_CLR_CH1B   2
`define TATC_BIT_CLR_CH2A   1
`define TATC_BIT_CLR_CH2B   0
`endif

/* File: include/tatc_pkg.sv */
// types shared by the converter trigger block
package tatc_pkg;
    typedef enum logic [1:0]
    {
        TATC_XFER_NONE   = 2'h0,
        TATC_XFER_CREST  = 2'h1,
        TATC_XFER_TROUGH = 2'h2,
        TATC_XFER_BOTH   = 2'h3
    } tatc_xfer_type;
endpackage : tatc_pkg

/* File: hw/tatc_trig_chan.sv */
// one converter trigger path: compare, direction gate, skip link, pulse
`timescale 1ns/1ps
`default_nettype none
module tatc_trig_chan #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    // counter state
    input  wire logic [WIDTH-1:0] count_in,
    input  wire logic             count_tick_in,
    input  wire logic             count_down_in,
    input  wire logic [WIDTH-1:0] cycle_in,
    // gating
    input  wire logic             up_en_in,
    input  wire logic             down_en_in,
    input  wire logic             link3_en_in,
    input  wire logic             link4_en_in,
    input  wire logic             skip3_in,
    input  wire logic             skip4_in,
    // trigger pulse
    output logic                  trig_out
);
    logic match;
    logic dir_ok;
    logic link_ok;
    logic trig_reg;
    logic trig_next;

    // a match counts only on the tick that lands on the value, so one pulse per match
    assign match     = count_tick_in && (count_in == cycle_in);
    assign dir_ok    = count_down_in ? down_en_in : up_en_in;
    // a linked trigger fires only in a period whose interrupt is not skipped
    assign link_ok   = !(link3_en_in && skip3_in) && !(link4_en_in && skip4_in);
    assign trig_next = match && dir_ok && link_ok;

    // single-cycle pulse toward the converter
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            trig_reg <= 1'b0;
        else
            trig_reg <= trig_next;
    end
    assign trig_out = trig_reg;

    AST_TRIG_PULSE: assert property (@(posedge clk_in) disable iff (srst_in)
        trig_out |=> !trig_out) else $error("trigger lasted over one cycle");
    AST_TRIG_CAUSE: assert property (@(posedge clk_in) disable iff (srst_in)
        trig_out |-> $past(match) && $past(dir_ok)) else $error("trigger without gated match");
endmodule : tatc_trig_chan
`default_nettype wire

/* File: hw/tatc_top.sv */
// converter start trigger control for timer channel 4, with counter-clear enables
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tatc_cfg.svh"
module tatc_top #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    // apb slave
    input  wire logic             psel_in,
    input  wire logic             penable_in,
    input  wire logic             pwrite_in,
    input  wire logic [11:0]      paddr_in,
    input  wire logic [31:0]      pwdata_in,
    input  wire logic [3:0]       pstrb_in,
    output logic                  pready_out,
    output logic [31:0]           prdata_out,
    output logic                  pslverr_out,
    // timer channel 3 and 4 state, same clock domain
    input  wire logic [WIDTH-1:0] ch4_counter_in,
    input  wire logic             ch4_count_tick_in,
    input  wire logic             ch4_count_down_in,
    input  wire logic             ch4_crest_in,
    input  wire logic             ch4_trough_in,
    input  wire logic             ch3_compare_a_irq_skip_in,
    input  wire logic             ch4_overflow_irq_skip_in,
    // compare flag set events from channels 1 and 2
    input  wire logic             ch1_compare_flag_b_set_in,
    input  wire logic             ch2_compare_flag_a_set_in,
    input  wire logic             ch2_compare_flag_b_set_in,
    // outputs
    output logic                  conv_trigger_a_out,
    output logic                  conv_trigger_b_out,
    output logic                  counter_clear_out
);
    logic [15:0]      adc_trigger_control_reg;
    logic [2:0]       clr_en_reg;
    logic [WIDTH-1:0] trig_cycle_a_reg;
    logic [WIDTH-1:0] trig_cycle_b_reg;
    logic [WIDTH-1:0] trig_cycle_buf_a_reg;
    logic [WIDTH-1:0] trig_cycle_buf_b_reg;
    logic             pready_reg;
    logic [31:0]      prdata_reg;
    logic             pslverr_reg;
    logic             clear_reg;
    logic             clear_next;
    logic [1:0]       trig_seen_reg;
    logic [1:0]       trig_seen_next;
    logic             trig_a;
    logic             trig_b;
    logic             setup;
    logic             wr;
    logic             rd;
    logic             mapped;
    logic             wr_ctrl;
    logic             wr_clr;
    logic             wr_buf_a;
    logic             wr_buf_b;
    logic             wr_cyc_a;
    logic             wr_cyc_b;
    logic             full_strobe;
    logic             xfer;
    logic [31:0]      rd_data;
    logic [15:0]      wdata16;
    tatc_pkg::tatc_xfer_type xfer_sel;

    // address match, used for every register
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction : hit

    // apb decode; answer in the setup cycle's following access cycle, no wait states
    assign setup       = psel_in && !penable_in;
    assign wr          = psel_in && penable_in && pwrite_in && pready_reg;
    assign rd          = setup && !pwrite_in;
    assign wdata16     = pwdata_in[15:0];
    // narrow writes are refused, except the status clear, so a byte write never splits a 16-bit value
    assign full_strobe = (pstrb_in[1:0] == 2'h3);
    assign mapped      = hit(paddr_in, `TATC_ADDR_CTRL) || hit(paddr_in, `TATC_ADDR_CYC_A)
                      || hit(paddr_in, `TATC_ADDR_CYC_B) || hit(paddr_in, `TATC_ADDR_BUF_A)
                      || hit(paddr_in, `TATC_ADDR_BUF_B) || hit(paddr_in, `TATC_ADDR_CLR_EN)
                      || hit(paddr_in, `TATC_ADDR_STATUS);
    assign wr_ctrl     = wr && full_strobe && hit(paddr_in, `TATC_ADDR_CTRL);
    assign wr_clr      = wr && full_strobe && hit(paddr_in, `TATC_ADDR_CLR_EN);
    assign wr_buf_a    = wr && full_strobe && hit(paddr_in, `TATC_ADDR_BUF_A);
    assign wr_buf_b    = wr && full_strobe && hit(paddr_in, `TATC_ADDR_BUF_B);
    assign wr_cyc_a    = wr && full_strobe && hit(paddr_in, `TATC_ADDR_CYC_A);
    assign wr_cyc_b    = wr && full_strobe && hit(paddr_in, `TATC_ADDR_CYC_B);

    // read mux; reserved and upper bits read zero
    assign rd_data = hit(paddr_in, `TATC_ADDR_CTRL)   ? {16'h0000, adc_trigger_control_reg}
                   : hit(paddr_in, `TATC_ADDR_CYC_A)  ? {16'h0000, trig_cycle_a_reg}
                   : hit(paddr_in, `TATC_ADDR_CYC_B)  ? {16'h0000, trig_cycle_b_reg}
                   : hit(paddr_in, `TATC_ADDR_BUF_A)  ? {16'h0000, trig_cycle_buf_a_reg}
                   : hit(paddr_in, `TATC_ADDR_BUF_B)  ? {16'h0000, trig_cycle_buf_b_reg}
                   : hit(paddr_in, `TATC_ADDR_CLR_EN) ? {29'h0000000, clr_en_reg}
                   : hit(paddr_in, `TATC_ADDR_STATUS) ? {29'h0000000, clear_reg, trig_seen_reg}
                   : 32'h00000000;

    // buffer to active copy point
    assign xfer_sel = tatc_pkg::tatc_xfer_type'(adc_trigger_control_reg[`TATC_BIT_XFER_HI:`TATC_BIT_XFER_LO]);
    assign xfer     = ((xfer_sel == tatc_pkg::TATC_XFER_CREST  || xfer_sel == tatc_pkg::TATC_XFER_BOTH)
                       && ch4_crest_in)
                   || ((xfer_sel == tatc_pkg::TATC_XFER_TROUGH || xfer_sel == tatc_pkg::TATC_XFER_BOTH)
                       && ch4_trough_in);

    // counter clear request from enabled flag events
    assign clear_next = (clr_en_reg[`TATC_BIT_CLR_CH1B] && ch1_compare_flag_b_set_in)
                     || (clr_en_reg[`TATC_BIT_CLR_CH2A] && ch2_compare_flag_a_set_in)
                     || (clr_en_reg[`TATC_BIT_CLR_CH2B] && ch2_compare_flag_b_set_in);

    // sticky trigger-seen status; a new trigger wins over a clearing write
    assign trig_seen_next = (wr && hit(paddr_in, `TATC_ADDR_STATUS)
                             ? trig_seen_reg & ~pwdata_in[1:0] : trig_seen_reg)
                          | {trig_b, trig_a};

    // apb handshake registers
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= setup;
            prdata_reg  <= rd ? rd_data : prdata_reg;
            pslverr_reg <= setup && (!mapped || (pwrite_in && !full_strobe));
        end
    end

    // control and clear-enable registers
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            adc_trigger_control_reg <= `TATC_CTRL_RESET;
            clr_en_reg              <= 3'(`TATC_CLR_RESET);
        end
        else
        begin
            if (wr_ctrl)
                adc_trigger_control_reg <= wdata16 & `TATC_CTRL_WMASK;
            if (wr_clr)
                clr_en_reg <= 3'(wdata16 & `TATC_CLR_WMASK);
        end
    end

    // cycle buffers and active cycle values
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            trig_cycle_buf_a_reg <= WIDTH'(`TATC_CYC_RESET);
            trig_cycle_buf_b_reg <= WIDTH'(`TATC_CYC_RESET);
            trig_cycle_a_reg     <= WIDTH'(`TATC_CYC_RESET);
            trig_cycle_b_reg     <= WIDTH'(`TATC_CYC_RESET);
        end
        else
        begin
            if (wr_buf_a)
                trig_cycle_buf_a_reg <= WIDTH'(wdata16);
            if (wr_buf_b)
                trig_cycle_buf_b_reg <= WIDTH'(wdata16);
            // the copy takes priority over a direct write in the same cycle
            if (xfer)
            begin
                trig_cycle_a_reg <= trig_cycle_buf_a_reg;
                trig_cycle_b_reg <= trig_cycle_buf_b_reg;
            end
            else
            begin
                if (wr_cyc_a)
                    trig_cycle_a_reg <= WIDTH'(wdata16);
                if (wr_cyc_b)
                    trig_cycle_b_reg <= WIDTH'(wdata16);
            end
        end
    end

    // status and clear output
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            clear_reg     <= 1'b0;
            trig_seen_reg <= 2'h0;
        end
        else
        begin
            clear_reg     <= clear_next;
            trig_seen_reg <= trig_seen_next;
        end
    end

    // trigger path A
    tatc_trig_chan #(
        .WIDTH(WIDTH)
    ) u_trig_a (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .count_in     (ch4_counter_in),
        .count_tick_in(ch4_count_tick_in),
        .count_down_in(ch4_count_down_in),
        .cycle_in     (trig_cycle_a_reg),
        .up_en_in     (adc_trigger_control_reg[`TATC_BIT_UP_A]),
        .down_en_in   (adc_trigger_control_reg[`TATC_BIT_DN_A]),
        .link3_en_in  (adc_trigger_control_reg[`TATC_BIT_LK_A3]),
        .link4_en_in  (adc_trigger_control_reg[`TATC_BIT_LK_A4]),
        .skip3_in     (ch3_compare_a_irq_skip_in),
        .skip4_in     (ch4_overflow_irq_skip_in),
        .trig_out     (trig_a)
    );

    // trigger path B
    tatc_trig_chan #(
        .WIDTH(WIDTH)
    ) u_trig_b (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .count_in     (ch4_counter_in),
        .count_tick_in(ch4_count_tick_in),
        .count_down_in(ch4_count_down_in),
        .cycle_in     (trig_cycle_b_reg),
        .up_en_in     (adc_trigger_control_reg[`TATC_BIT_UP_B]),
        .down_en_in   (adc_trigger_control_reg[`TATC_BIT_DN_B]),
        .link3_en_in  (adc_trigger_control_reg[`TATC_BIT_LK_B3]),
        .link4_en_in  (adc_trigger_control_reg[`TATC_BIT_LK_B4]),
        .skip3_in     (ch3_compare_a_irq_skip_in),
        .skip4_in     (ch4_overflow_irq_skip_in),
        .trig_out     (trig_b)
    );

    // outputs, all from flip-flops
    assign pready_out         = pready_reg;
    assign prdata_out         = prdata_reg;
    assign pslverr_out        = pslverr_reg;
    assign conv_trigger_a_out = trig_a;
    assign conv_trigger_b_out = trig_b;
    assign counter_clear_out  = clear_reg;

    AST_CLR_CH1B: assert property (@(posedge clk_in) disable iff (srst_in)
        ch1_compare_flag_b_set_in && clr_en_reg[`TATC_BIT_CLR_CH1B] |=> counter_clear_out)
        else $error("enabled channel 1 flag B did not clear");
    AST_CLR_CH2A: assert property (@(posedge clk_in) disable iff (srst_in)
        ch2_compare_flag_a_set_in && clr_en_reg[`TATC_BIT_CLR_CH2A] |=> counter_clear_out)
        else $error("enabled channel 2 flag A did not clear");
    AST_CLR_CH2B: assert property (@(posedge clk_in) disable iff (srst_in)
        ch2_compare_flag_b_set_in && clr_en_reg[`TATC_BIT_CLR_CH2B] |=> counter_clear_out)
        else $error("enabled channel 2 flag B did not clear");
    AST_CLR_CAUSE: assert property (@(posedge clk_in) disable iff (srst_in)
        counter_clear_out |-> $past(clear_next)) else $error("clear without enabled flag");
    AST_CTRL_WRITE: assert property (@(posedge clk_in) disable iff (srst_in)
        wr_ctrl |=> adc_trigger_control_reg == ($past(wdata16) & `TATC_CTRL_WMASK))
        else $error("control write not stored");
    AST_RSVD_ZERO: assert property (@(posedge clk_in) disable iff (srst_in)
        adc_trigger_control_reg[13:8] == 6'h00) else $error("reserved control bits set");
    AST_XFER_CREST: assert property (@(posedge clk_in) disable iff (srst_in)
        xfer_sel == tatc_pkg::TATC_XFER_CREST && ch4_crest_in
        |=> trig_cycle_a_reg == $past(trig_cycle_buf_a_reg)) else $error("crest copy missed");
    AST_XFER_NONE: assert property (@(posedge clk_in) disable iff (srst_in)
        xfer_sel == tatc_pkg::TATC_XFER_NONE && !wr_cyc_a |=> $stable(trig_cycle_a_reg))
        else $error("copy happened with timing none");
    AST_UP_GATE_A: assert property (@(posedge clk_in) disable iff (srst_in)
        ch4_count_tick_in && !ch4_count_down_in && !adc_trigger_control_reg[`TATC_BIT_UP_A]
        |=> !conv_trigger_a_out) else $error("trigger A while up count disabled");
    AST_SKIP_B: assert property (@(posedge clk_in) disable iff (srst_in)
        adc_trigger_control_reg[`TATC_BIT_LK_B4] && ch4_overflow_irq_skip_in
        |=> !conv_trigger_b_out) else $error("trigger B in skipped period");

    COV_TRIG_A: cover property (@(posedge clk_in) disable iff (srst_in) conv_trigger_a_out);
    COV_TRIG_B: cover property (@(posedge clk_in) disable iff (srst_in) conv_trigger_b_out);
    COV_XFER: cover property (@(posedge clk_in) disable iff (srst_in) xfer);
    COV_CLEAR: cover property (@(posedge clk_in) disable iff (srst_in) counter_clear_out);
endmodule : tatc_top
`default_nettype wire

/* File: sim/tatc_conv_model.sv */
// converter start-request input model: counts requests and flags stretched pulses
`timescale 1ns/1ps
`default_nettype none
module tatc_conv_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // start requests from the trigger block
    input  wire logic        trig_a_in,
    input  wire logic        trig_b_in,
    // request counts and pulse-width fault
    output logic [15:0]      starts_a_out,
    output logic [15:0]      starts_b_out,
    output logic             wide_out
);
    logic last_a_reg;
    logic last_b_reg;

    // a level held over two clocks would start the converter twice, so it is flagged
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            last_a_reg   <= 1'b0;
            last_b_reg   <= 1'b0;
            starts_a_out <= 16'h0000;
            starts_b_out <= 16'h0000;
            wide_out     <= 1'b0;
        end
        else
        begin
            last_a_reg   <= trig_a_in;
            last_b_reg   <= trig_b_in;
            starts_a_out <= starts_a_out + 16'(trig_a_in & ~last_a_reg);
            starts_b_out <= starts_b_out + 16'(trig_b_in & ~last_b_reg);
            wide_out     <= wide_out | (trig_a_in & last_a_reg) | (trig_b_in & last_b_reg);
        end
    end
endmodule : tatc_conv_model
`default_nettype wire

/* File: sim/tatc_tb_top.sv */
// self-checking bench: register access, trigger gating, copy timing, counter clear
`timescale 1ns/1ps
`default_nettype none
`include "tatc_cfg.svh"
module timer_adc_trigger_control_tb_top;
    // design inputs, all given a value at time zero
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h00000000;
    logic [3:0]  pstrb_in = 4'h0;
    logic [15:0] cnt = 16'h0000;
    logic        tick = 1'b0, dn = 1'b0, crest = 1'b0, trough = 1'b0, sk3 = 1'b0, sk4 = 1'b0;
    logic [2:0]  flags = 3'h0;
    // design outputs and model state
    wire logic        pready_out, pslverr_out, trig_a, trig_b, clr, wide;
    wire logic [31:0] prdata_out;
    wire logic [15:0] starts_a, starts_b;
    int               err_count = 0;
    int               samples_checked = 0;
    logic [15:0]      ctrl_m, cyc_a_m, cyc_b_m, buf_a_m, buf_b_m, exp_a_n = 16'h0, exp_b_n = 16'h0, c;
    logic [2:0]       clr_m = 3'h0;
    logic [31:0]      rdat;
    logic             rerr;

    always #10 clk_in = ~clk_in;

    tatc_top #(.WIDTH(16)) dut_u (
        .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
        .ch4_counter_in(cnt), .ch4_count_tick_in(tick), .ch4_count_down_in(dn),
        .ch4_crest_in(crest), .ch4_trough_in(trough), .ch3_compare_a_irq_skip_in(sk3),
        .ch4_overflow_irq_skip_in(sk4), .ch1_compare_flag_b_set_in(flags[2]),
        .ch2_compare_flag_a_set_in(flags[1]), .ch2_compare_flag_b_set_in(flags[0]),
        .conv_trigger_a_out(trig_a), .conv_trigger_b_out(trig_b), .counter_clear_out(clr));

    tatc_conv_model conv_u (.clk_in(clk_in), .srst_in(srst_in), .trig_a_in(trig_a), .trig_b_in(trig_b),
        .starts_a_out(starts_a), .starts_b_out(starts_b), .wide_out(wide));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // one apb transfer; request held until the rising edge at which ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        bit done;
        done = 1'b0;
        @(posedge clk_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        pstrb_in   <= s;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // ready is registered, so at the edge the old value is still seen here
        for (int n = 0; n < 16 && !done; n++)
        begin
            @(posedge clk_in);
            if (pready_out === 1'b1)
            begin
                rdat = prdata_out;
                rerr = pslverr_out;
                done = 1'b1;
            end
        end
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        if (!done)
        begin
            check(32'h0, 32'h1);
            tally_and_finish();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d}, 4'hf);
        check(32'(rerr), 32'h0);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        check(rdat, exp);
    endtask : rdchk

    // one counter tick; expected gating worked out from the control model
    task automatic tick_chk(input logic [15:0] v, input logic d, input logic s3, input logic s4);
        logic ea;
        logic eb;
        ea = (v == cyc_a_m) && (d ? ctrl_m[6] : ctrl_m[7]) && !(ctrl_m[3] && s3) && !(ctrl_m[2] && s4);
        eb = (v == cyc_b_m) && (d ? ctrl_m[4] : ctrl_m[5]) && !(ctrl_m[1] && s3) && !(ctrl_m[0] && s4);
        exp_a_n += 16'(ea);
        exp_b_n += 16'(eb);
        @(posedge clk_in);
        cnt  <= v;
        dn   <= d;
        sk3  <= s3;
        sk4  <= s4;
        tick <= 1'b1;
        @(posedge clk_in);
        tick <= 1'b0;
        @(negedge clk_in);
        check(32'(trig_a), 32'(ea));
        check(32'(trig_b), 32'(eb));
    endtask : tick_chk

    // crest or trough pulse; the copy lands in the active model when selected
    task automatic peak(input logic cr, input logic tr);
        @(posedge clk_in);
        crest  <= cr;
        trough <= tr;
        @(posedge clk_in);
        crest  <= 1'b0;
        trough <= 1'b0;
        if ((cr && ctrl_m[14]) || (tr && ctrl_m[15]))
        begin
            cyc_a_m = buf_a_m;
            cyc_b_m = buf_b_m;
        end
    endtask : peak

    task automatic flag_chk(input logic [2:0] f);
        @(posedge clk_in);
        flags <= f;
        @(posedge clk_in);
        flags <= 3'h0;
        @(negedge clk_in);
        check(32'(clr), 32'(|(f & clr_m)));
    endtask : flag_chk

    // main sequence: reset values, refusals, copy modes, random mix, second reset
    initial
    begin
        void'($urandom(32'h9f5d889f));
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        rdchk(`TATC_ADDR_CTRL, 32'h0);
        rdchk(`TATC_ADDR_CYC_A, 32'h0000ffff);
        rdchk(`TATC_ADDR_CYC_B, 32'h0000ffff);
        rdchk(`TATC_ADDR_CLR_EN, 32'h0);
        {cyc_a_m, cyc_b_m, buf_a_m, buf_b_m} = {4{16'hffff}};
        // all-ones active values must match a counter sitting at ffff
        ctrl_m = 16'h00a0;
        wr(`TATC_ADDR_CTRL, ctrl_m);
        tick_chk(16'hffff, 1'b0, 1'b0, 1'b0);
        // both triggers fired once, so both sticky seen bits stand until cleared
        rdchk(`TATC_ADDR_STATUS, 32'h3);
        wr(`TATC_ADDR_STATUS, 16'h0003);
        rdchk(`TATC_ADDR_STATUS, 32'h0);
        // reserved bits never read back, even after ones land there
        wr(`TATC_ADDR_CTRL, 16'hffff);
        rdchk(`TATC_ADDR_CTRL, 32'h0000c0ff);
        ctrl_m = 16'hc0ff;
        apb(1'b1, `TATC_ADDR_CTRL, 32'h0, 4'h1);
        check(32'(rerr), 32'h1);
        rdchk(`TATC_ADDR_CTRL, 32'h0000c0ff);
        apb(1'b0, 12'h020, 32'h0, 4'h0);
        check({rdat[30:0], rerr}, 32'h1);
        // each copy select value, crest then trough with fresh buffers
        for (int s = 0; s < 4; s++)
        begin
            ctrl_m = {2'(s), 14'h0000};
            wr(`TATC_ADDR_CTRL, ctrl_m);
            for (int p = 0; p < 2; p++)
            begin
                buf_a_m = 16'($urandom);
                buf_b_m = 16'($urandom);
                wr(`TATC_ADDR_BUF_A, buf_a_m);
                wr(`TATC_ADDR_BUF_B, buf_b_m);
                peak(p == 0, p == 1);
                rdchk(`TATC_ADDR_CYC_A, {16'h0, cyc_a_m});
                rdchk(`TATC_ADDR_CYC_B, {16'h0, cyc_b_m});
            end
        end
        // random enables, links, cycle values and clear enables
        repeat (60)
        begin
            // the bench plays complementary mode, where down enables and links may be set
            ctrl_m = 16'($urandom) & 16'h00ff;
            clr_m = 3'($urandom);
            cyc_a_m = 16'($urandom);
            cyc_b_m = ($urandom % 4 == 0) ? cyc_a_m : 16'($urandom);
            wr(`TATC_ADDR_CTRL, ctrl_m);
            wr(`TATC_ADDR_CLR_EN, {13'h0, clr_m});
            wr(`TATC_ADDR_CYC_A, cyc_a_m);
            wr(`TATC_ADDR_CYC_B, cyc_b_m);
            c = ($urandom % 3 == 0) ? 16'($urandom) : (($urandom % 2 == 0) ? cyc_a_m : cyc_b_m);
            tick_chk(c, 1'($urandom), 1'($urandom), 1'($urandom));
            flag_chk(3'($urandom));
        end
        repeat (2) @(posedge clk_in);
        check({starts_a, starts_b}, {exp_a_n, exp_b_n});
        check(32'(wide), 32'h0);
        // reset in mid-run restores the control register
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        rdchk(`TATC_ADDR_CTRL, 32'h0);
        rdchk(`TATC_ADDR_CYC_A, 32'h0000ffff);
        tally_and_finish();
    end
endmodule : timer_adc_trigger_control_tb_top
`default_nettype wire
